// *** gated_timer.sv ***
// Gated 16-bit timer/counter with Avalon-MM register access
`timescale 1ns/1ns
// Function
// - Byte-writable 16-bit up counter
// - Timer-on and gate-enable decide counting
// - Clock select field plus crystal enable
// - Internal clock advances per prescaled period
// - System clock gives four per instruction
// - External rising edge, synced or not
// - Falling edge needed before first count
// - Prescale by 1, 2, 4, 8
// - Prescaler hidden, cleared on count write
// - Crystal oscillator enable, runs in sleep
// - Unsynced external counts in sleep, wakes
// - Mode switch may skip or add one
// - Byte reads of running count valid
// - Gate enable and gate polarity bits
// - Gated count when gate matches polarity
// - Two gate sources, codes 10 and 11 give a low gate, polarity applies
// - Source 00 pin, 01 companion overflow
// - Companion overflow pulse feeds gate
// - Wrap sets overflow flag, software clears
module gated_timer
	import timer_pkg::*;
#(
	parameter int COUNT_W = 16
)
(
	input wire logic mclk, // Clock 250 MHz
	input wire logic rst_n, // Async reset, active low
	input wire logic [ADDR_W-1:0] address, // Avalon byte address
	input wire logic read, // Avalon read
	input wire logic write, // Avalon write
	input wire logic [DATA_W-1:0] writedata, // Avalon write data
	input wire logic [3:0] byteenable, // Avalon byte enables
	output logic [DATA_W-1:0] readdata, // Avalon read data
	output logic waitrequest, // Avalon wait
	input wire logic ext_count_input, // External count pin
	input wire logic crystal_in, // Crystal amplifier input
	input wire logic gate_pin, // External gate pin
	input wire logic companion_ovf, // Companion timer wrap pulse
	input wire logic sleep, // Processor in sleep
	output logic crystal_out, // Crystal amplifier output
	output logic ovf_flag, // Overflow flag level
	output logic wake_pulse // Overflow wake in sleep
);
	import timer_pkg::*;
	if (COUNT_W != 2 * BYTE_W)
	begin : g_chk
		$error("gated_timer count must be two bytes");
	end
	// ==========================================
	// Reset release
	logic rst_m_r;
	logic rst_n_s;
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rst_m_r <= 1'b0;
			rst_n_s <= 1'b0;
		end
		else
		begin
			rst_m_r <= 1'b1;
			rst_n_s <= rst_m_r;
		end
	end
	// ==========================================
	// Bus slave
	logic req;
	logic acc;
	logic wr_lane;
	logic wr_lo;
	logic wr_hi;
	logic wr_tc;
	logic wr_gc;
	logic wr_st;
	logic [7:0] timer_ctrl_r;
	logic [7:0] gate_ctrl_r;
	logic [COUNT_W-1:0] count_r;
	logic gate_val_r;
	logic [DATA_W-1:0] rd_nxt;
	assign req = read || write;
	assign acc = req && !waitrequest;
	assign wr_lane = write && acc && byteenable[0];
	assign wr_lo = wr_lane && address == OFS_COUNT_LOW;
	assign wr_hi = wr_lane && address == OFS_COUNT_HIGH;
	assign wr_tc = wr_lane && address == OFS_TIMER_CTRL;
	assign wr_gc = wr_lane && address == OFS_GATE_CTRL;
	assign wr_st = wr_lane && address == OFS_STATUS;
	always_ff @(posedge mclk or negedge rst_n_s)
	begin
		if (!rst_n_s)
			waitrequest <= 1'b1;
		else
			waitrequest <= !(req && waitrequest);
	end
	always_comb
	begin
		rd_nxt = '0;
		unique case (address)
			OFS_COUNT_LOW: rd_nxt[7:0] = count_r[7:0];
			OFS_COUNT_HIGH: rd_nxt[7:0] = count_r[15:8];
			OFS_TIMER_CTRL: rd_nxt[7:0] = timer_ctrl_r;
			OFS_GATE_CTRL: rd_nxt[7:0] = {gate_ctrl_r[7:3], gate_val_r, gate_ctrl_r[1:0]};
			OFS_STATUS: rd_nxt[ST_OVF] = ovf_flag;
			default: rd_nxt = '0;
		endcase
	end
	always_ff @(posedge mclk or negedge rst_n_s)
	begin
		if (!rst_n_s)
			readdata <= '0;
		else if (read && waitrequest)
			readdata <= rd_nxt;
	end
	// ==========================================
	// Control registers
	always_ff @(posedge mclk or negedge rst_n_s)
	begin
		if (!rst_n_s)
			timer_ctrl_r <= TIMER_CTRL_RST;
		else if (wr_tc)
			timer_ctrl_r <= {writedata[7:2], 1'b0, writedata[0]};
	end
	always_ff @(posedge mclk or negedge rst_n_s)
	begin
		if (!rst_n_s)
			gate_ctrl_r <= GATE_CTRL_RST;
		else if (wr_gc)
			gate_ctrl_r <= {writedata[7:6], 3'b000, 1'b0, writedata[1:0]};
	end
	logic timer_on;
	logic no_sync_select;
	logic crystal_osc_enable;
	logic [1:0] prescale_select;
	clk_sel_type clock_select;
	logic gate_enable;
	logic gate_polarity;
	gate_src_type gate_source_select;
	assign timer_on = timer_ctrl_r[TC_ON];
	assign no_sync_select = timer_ctrl_r[TC_NOSYNC];
	assign crystal_osc_enable = timer_ctrl_r[TC_OSCEN];
	assign prescale_select = timer_ctrl_r[TC_PS_LO +: 2];
	assign clock_select = clk_sel_type'(timer_ctrl_r[TC_CS_LO +: 2]);
	assign gate_enable = gate_ctrl_r[GC_EN];
	assign gate_polarity = gate_ctrl_r[GC_POL];
	assign gate_source_select = gate_src_type'(gate_ctrl_r[GC_SRC_LO +: 2]);
	// ==========================================
	// Crystal oscillator amplifier, alive in sleep
	always_ff @(posedge mclk or negedge rst_n_s)
	begin
		if (!rst_n_s)
			crystal_out <= 1'b0;
		else
			crystal_out <= crystal_osc_enable && !crystal_in;
	end
	// ==========================================
	// Instruction clock divider
	logic [1:0] inst_cnt_r;
	logic inst_tick;
	always_ff @(posedge mclk or negedge rst_n_s)
	begin
		if (!rst_n_s)
			inst_cnt_r <= '0;
		else
			inst_cnt_r <= inst_cnt_r + 2'h1;
	end
	assign inst_tick = inst_cnt_r == INST_LAST;
	// ==========================================
	// External edge detection
	logic ext_src;
	logic sync1_r;
	logic sync2_r;
	logic sync3_r;
	logic raw_prev_r;
	logic ext_rise;
	logic ext_fall;
	logic armed_r;
	assign ext_src = crystal_osc_enable ? crystal_in : ext_count_input;
	always_ff @(posedge mclk or negedge rst_n_s)
	begin
		if (!rst_n_s)
		begin
			sync1_r <= 1'b0;
			sync2_r <= 1'b0;
			sync3_r <= 1'b0;
			raw_prev_r <= 1'b0;
		end
		else
		begin
			sync1_r <= ext_src;
			sync2_r <= sync1_r;
			sync3_r <= sync2_r;
			raw_prev_r <= ext_src;
		end
	end
	// Resync path stalls in sleep; raw path keeps going
	always_comb
	begin
		if (no_sync_select)
		begin
			ext_rise = ext_src && !raw_prev_r;
			ext_fall = !ext_src && raw_prev_r;
		end
		else
		begin
			ext_rise = sync2_r && !sync3_r && !sleep;
			ext_fall = !sync2_r && sync3_r && !sleep;
		end
	end
	// Falling edge arms the counter after enable or write
	always_ff @(posedge mclk or negedge rst_n_s)
	begin
		if (!rst_n_s)
			armed_r <= 1'b0;
		else if (!timer_on || wr_lo || wr_hi)
			armed_r <= 1'b0;
		else if (ext_fall)
			armed_r <= 1'b1;
	end
	// ==========================================
	// Source selection and prescale
	logic src_tick;
	logic ps_tick;
	always_comb
	begin
		unique case (clock_select)
			CS_INST: src_tick = inst_tick && !sleep;
			CS_SYS: src_tick = !sleep;
			CS_EXT: src_tick = ext_rise && armed_r;
			CS_RSVD: src_tick = 1'b0;
		endcase
	end
	count_prescaler u_prescaler
	(
		.mclk(mclk),
		.rst_n_s(rst_n_s),
		.src_tick(src_tick),
		.clear(wr_lo || wr_hi),
		.sel(prescale_select),
		.tick_out(ps_tick)
	);
	// ==========================================
	// Gate
	logic gate_src;
	logic gate_match;
	logic count_en;
	always_comb
	begin
		unique case (gate_source_select)
			GS_PIN: gate_src = gate_pin;
			GS_COMP_OVF: gate_src = companion_ovf;
			default: gate_src = 1'b0;
		endcase
	end
	always_ff @(posedge mclk or negedge rst_n_s)
	begin
		if (!rst_n_s)
			gate_val_r <= 1'b0;
		else
			gate_val_r <= gate_src == gate_polarity;
	end
	assign gate_match = gate_src == gate_polarity;
	assign count_en = timer_on && (!gate_enable || gate_match);
	// ==========================================
	// Counter and overflow
	logic inc;
	logic wrap;
	assign inc = ps_tick && count_en && clock_select != CS_RSVD;
	assign wrap = inc && &count_r && !wr_lo && !wr_hi;
	always_ff @(posedge mclk or negedge rst_n_s)
	begin
		if (!rst_n_s)
			count_r <= COUNT_RST;
		else if (wr_lo)
			count_r <= {count_r[15:8], writedata[7:0]};
		else if (wr_hi)
			count_r <= {writedata[7:0], count_r[7:0]};
		else if (inc)
			count_r <= count_r + 16'h0001;
	end
	always_ff @(posedge mclk or negedge rst_n_s)
	begin
		if (!rst_n_s)
			ovf_flag <= 1'b0;
		else if (wrap)
			ovf_flag <= 1'b1;
		else if (wr_st && writedata[ST_OVF])
			ovf_flag <= 1'b0;
	end
	always_ff @(posedge mclk or negedge rst_n_s)
	begin
		if (!rst_n_s)
			wake_pulse <= 1'b0;
		else
			wake_pulse <= wrap && sleep;
	end
	// ==========================================
	// Checks
	low_write_a: assert property (@(posedge mclk) disable iff (!rst_n_s)
		wr_lo |=> count_r[7:0] == $past(writedata[7:0]))
		else $error("low byte write lost");
	off_hold_a: assert property (@(posedge mclk) disable iff (!rst_n_s)
		!timer_on && !wr_lo && !wr_hi |=> count_r == $past(count_r))
		else $error("count moved while off");
	step_one_a: assert property (@(posedge mclk) disable iff (!rst_n_s)
		ps_tick && count_en && clock_select == CS_SYS && !wr_lo && !wr_hi
		|=> count_r == $past(count_r) + 16'h0001)
		else $error("count did not step");
	sys_rate_a: assert property (@(posedge mclk) disable iff (!rst_n_s)
		timer_on && !gate_enable && clock_select == CS_SYS && prescale_select == 2'b00
		&& !sleep && !wr_lo && !wr_hi && !wr_tc ##1 $stable(timer_ctrl_r) && !sleep
		|-> ps_tick)
		else $error("system clock not every cycle");
	arm_clear_a: assert property (@(posedge mclk) disable iff (!rst_n_s)
		wr_lo || wr_hi |=> !armed_r)
		else $error("write did not disarm");
	gate_hold_a: assert property (@(posedge mclk) disable iff (!rst_n_s)
		gate_enable && !gate_match && !wr_lo && !wr_hi |=> $stable(count_r))
		else $error("gated count moved");
	rsvd_hold_a: assert property (@(posedge mclk) disable iff (!rst_n_s)
		clock_select == CS_RSVD && !wr_lo && !wr_hi |=> $stable(count_r))
		else $error("reserved clock counted");
	ovf_set_a: assert property (@(posedge mclk) disable iff (!rst_n_s)
		wrap |=> ovf_flag && count_r == 16'h0000)
		else $error("overflow flag not set");
	bus_ack_a: assert property (@(posedge mclk) disable iff (!rst_n_s)
		req && waitrequest |=> !waitrequest)
		else $error("bus answer late");
	ovf_cov: cover property (@(posedge mclk) disable iff (!rst_n_s) wrap);
	ext_cov: cover property (@(posedge mclk) disable iff (!rst_n_s)
		inc && clock_select == CS_EXT);
	gate_cov: cover property (@(posedge mclk) disable iff (!rst_n_s)
		gate_enable && timer_on && !gate_match ##1 gate_match);
endmodule : gated_timer

// *** timer_pkg.sv ***
// Constants, register map and field layout of the gated 16-bit timer
package timer_pkg;
	// ==========================================
	// Register word offsets (byte addresses)
	localparam logic [4:0] OFS_COUNT_LOW = 5'h00;
	localparam logic [4:0] OFS_COUNT_HIGH = 5'h04;
	localparam logic [4:0] OFS_TIMER_CTRL = 5'h08;
	localparam logic [4:0] OFS_GATE_CTRL = 5'h0C;
	localparam logic [4:0] OFS_STATUS = 5'h10;
	localparam int ADDR_W = 5;
	localparam int DATA_W = 32;
	localparam int BYTE_W = 8;
	// ==========================================
	// Timer control field positions
	localparam int TC_ON = 0;
	localparam int TC_NOSYNC = 2;
	localparam int TC_OSCEN = 3;
	localparam int TC_PS_LO = 4;
	localparam int TC_CS_LO = 6;
	// ==========================================
	// Gate control field positions
	localparam int GC_SRC_LO = 0;
	localparam int GC_VAL = 2;
	localparam int GC_POL = 6;
	localparam int GC_EN = 7;
	// ==========================================
	// Status field positions
	localparam int ST_OVF = 0;
	// ==========================================
	// Reset values
	localparam logic [7:0] TIMER_CTRL_RST = 8'h00;
	localparam logic [7:0] GATE_CTRL_RST = 8'h00;
	localparam logic [15:0] COUNT_RST = 16'h0000;
	// ==========================================
	// Timing
	localparam int INST_DIV = 4;
	localparam logic [1:0] INST_LAST = 2'h3;
	localparam int PS_W = 3;
	// ==========================================
	// Encodings
	typedef enum logic [1:0]
	{
		CS_INST = 2'b00,
		CS_SYS = 2'b01,
		CS_EXT = 2'b10,
		CS_RSVD = 2'b11
	} clk_sel_type;
	typedef enum logic [1:0]
	{
		GS_PIN = 2'b00,
		GS_COMP_OVF = 2'b01,
		GS_RSVD2 = 2'b10,
		GS_RSVD3 = 2'b11
	} gate_src_type;
endpackage : timer_pkg

// *** count_prescaler.sv ***
// Divide-by-1/2/4/8 prescaler for the count clock pulses
`timescale 1ns/1ns
module count_prescaler
	import timer_pkg::*;
#(
	parameter int PSW = PS_W
)
(
	input wire logic mclk, // Clock
	input wire logic rst_n_s, // Synchronised reset
	input wire logic src_tick, // Source clock pulse
	input wire logic clear, // Clear counter
	input wire logic [1:0] sel, // Divide select
	output logic tick_out // Prescaled pulse
);
	import timer_pkg::*;
	if (PSW != 3)
	begin : g_chk
		$error("count_prescaler needs a 3-bit counter");
	end
	logic [PSW-1:0] cnt_r;
	logic [PSW-1:0] mask;
	always_comb
	begin
		mask = PSW'((1 << sel) - 1);
	end
	// ==========================================
	// Hidden prescale counter
	always_ff @(posedge mclk or negedge rst_n_s)
	begin
		if (!rst_n_s)
			cnt_r <= '0;
		else if (clear)
			cnt_r <= '0;
		else if (src_tick)
			cnt_r <= (cnt_r & mask) == mask ? '0 : cnt_r + 1'b1;
	end
	always_ff @(posedge mclk or negedge rst_n_s)
	begin
		if (!rst_n_s)
			tick_out <= 1'b0;
		else
			tick_out <= src_tick && !clear && ((cnt_r & mask) == mask);
	end
	// ==========================================
	// Checks
	ps_clear_a: assert property (@(posedge mclk) disable iff (!rst_n_s)
		clear |=> cnt_r == '0 && !tick_out)
		else $error("prescaler not cleared");
	ps_div8_a: assert property (@(posedge mclk) disable iff (!rst_n_s)
		tick_out && sel == 2'b11 && $past(sel) == 2'b11 |-> $past(cnt_r) == 3'h7)
		else $error("divide by eight wrong");
endmodule : count_prescaler

// *** link_partner.sv ***
// Model of the external count source, crystal and gate sources
`timescale 1ns/1ns
module link_partner
(
	input wire logic mclk, // Clock
	input wire logic ext_run, // Toggle count pin
	input wire logic xtal_run, // Run crystal
	input wire logic comp_run, // Pulse companion wrap
	input wire logic gate_lvl, // Gate pin level
	output logic ext_count_input, // Count pin
	output logic crystal_in, // Crystal input
	output logic gate_pin, // Gate pin
	output logic companion_ovf // Companion wrap pulse
);
	logic [3:0] phase_r = 4'h0;
	initial ext_count_input = 1'b0;
	initial crystal_in = 1'b0;
	initial companion_ovf = 1'b0;
	assign gate_pin = gate_lvl;
	// Pin clocks stand still while not running
	always @(posedge mclk)
	begin
		phase_r <= phase_r + 4'h1;
		if (ext_run && phase_r[1:0] == 2'h3)
			ext_count_input <= ~ext_count_input;
		if (xtal_run && phase_r[1:0] == 2'h1)
			crystal_in <= ~crystal_in;
		companion_ovf <= comp_run && phase_r == 4'hF;
	end
endmodule : link_partner

// *** testbench.sv ***
// Self-checking testbench of the gated timer
`timescale 1ns/1ns
module testbench;
	import timer_pkg::*;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic [4:0] address = 5'h00;
	logic read = 1'b0;
	logic write = 1'b0;
	logic [31:0] writedata = 32'h0000_0000;
	logic [3:0] byteenable = 4'hF;
	logic [31:0] readdata;
	logic waitrequest, ovf_flag, wake_pulse, sleep = 1'b0;
	logic ext_count_input, crystal_in, gate_pin, companion_ovf, crystal_out;
	logic ext_run = 1'b0, xtal_run = 1'b0, comp_run = 1'b0, gate_lvl = 1'b0;
	int miscompares = 0;
	int check_count = 0;
	always #2 mclk = ~mclk;
	gated_timer dut (.mclk(mclk), .rst_n(rst_n), .address(address), .read(read),
		.write(write), .writedata(writedata), .byteenable(byteenable),
		.readdata(readdata), .waitrequest(waitrequest),
		.ext_count_input(ext_count_input), .crystal_in(crystal_in),
		.gate_pin(gate_pin), .companion_ovf(companion_ovf), .sleep(sleep),
		.crystal_out(crystal_out), .ovf_flag(ovf_flag), .wake_pulse(wake_pulse));
	link_partner far_end (.mclk(mclk), .ext_run(ext_run), .xtal_run(xtal_run),
		.comp_run(comp_run), .gate_lvl(gate_lvl), .ext_count_input(ext_count_input),
		.crystal_in(crystal_in), .gate_pin(gate_pin), .companion_ovf(companion_ovf));
	// ==========================================
	// Checks and bus access
	task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task check_rng(input string what, input logic [15:0] c, input int exp);
		check(what, {15'h0000, (c >= exp - 2 && c <= exp + 4)}, 16'h0001);
	endtask : check_rng
	task bus(input logic [4:0] a, input logic wr, input logic [7:0] d,
		input logic [3:0] be, output logic [7:0] q);
		int n;
		n = 0;
		@(posedge mclk);
		address <= a;
		writedata <= {24'h00_0000, d};
		byteenable <= be;
		write <= wr;
		read <= ~wr;
		do
		begin
			@(posedge mclk);
			n++;
		end
		while (waitrequest !== 1'b0 && n < 50);
		q = readdata[7:0];
		write <= 1'b0;
		read <= 1'b0;
		if (n >= 50)
			miscompares++;
	endtask : bus
	task wr(input logic [4:0] a, input logic [7:0] d);
		logic [7:0] q;
		bus(a, 1'b1, d, 4'hF, q);
	endtask : wr
	task rd(input logic [4:0] a, output logic [7:0] q);
		bus(a, 1'b0, 8'h00, 4'hF, q);
	endtask : rd
	// Clear count, run for a span, stop, read both bytes
	task run(input logic [7:0] tc, input logic [7:0] gc, input int cyc,
		output logic [15:0] c);
		logic [7:0] lo, hi;
		wr(OFS_TIMER_CTRL, tc & 8'hFE);
		wr(OFS_COUNT_LOW, 8'h00);
		wr(OFS_COUNT_HIGH, 8'h00);
		wr(OFS_GATE_CTRL, gc);
		wr(OFS_TIMER_CTRL, tc);
		repeat (cyc) @(posedge mclk);
		wr(OFS_TIMER_CTRL, tc & 8'hFE);
		rd(OFS_COUNT_LOW, lo);
		rd(OFS_COUNT_HIGH, hi);
		c = {hi, lo};
	endtask : run
	// ==========================================
	// Scenarios
	task test_reset();
		logic [7:0] q;
		rd(OFS_TIMER_CTRL, q);
		check("timer_ctrl", {8'h00, q}, {8'h00, TIMER_CTRL_RST});
		rd(OFS_GATE_CTRL, q);
		check("gate_ctrl", {8'h00, q & 8'hFB}, {8'h00, GATE_CTRL_RST});
		rd(OFS_STATUS, q);
		check("status", {8'h00, q}, 16'h0000);
		rd(OFS_COUNT_LOW, q);
		check("count_low", {8'h00, q}, COUNT_RST & 16'h00FF);
		check("crystal_out", {15'h0000, crystal_out}, 16'h0000);
		$display("test reset done");
	endtask : test_reset
	task test_bytes();
		logic [7:0] q;
		wr(OFS_COUNT_LOW, 8'hA5);
		wr(OFS_COUNT_HIGH, 8'h3C);
		bus(OFS_COUNT_LOW, 1'b1, 8'h11, 4'hE, q);
		wr(5'h14, 8'h77);
		rd(OFS_COUNT_LOW, q);
		check("count_low", {8'h00, q}, 16'h00A5);
		rd(OFS_COUNT_HIGH, q);
		check("count_high", {8'h00, q}, 16'h003C);
		rd(5'h14, q);
		check("unmapped", {8'h00, q}, 16'h0000);
		$display("test bytes done");
	endtask : test_bytes
	task test_clocks();
		logic [15:0] c;
		for (int ps = 0; ps < 4; ps++)
		begin
			run({2'b01, ps[1:0], 4'h1}, 8'h00, 128, c);
			check_rng("sys_prescaled", c, 128 >> ps);
		end
		run(8'h01, 8'h00, 128, c);
		check_rng("inst_clock", c, 32);
		run(8'hC1, 8'h00, 128, c);
		check("reserved_clock", c, 16'h0000);
		run(8'h40, 8'h80, 128, c);
		check("timer_off", c, 16'h0000);
		$display("test clocks done");
	endtask : test_clocks
	task test_gate();
		logic [15:0] c;
		logic [7:0] q;
		for (int i = 0; i < 4; i++)
		begin
			gate_lvl <= i[0];
			run(8'h41, {1'b1, i[1], 6'h00}, 128, c);
			if (i[0] == i[1])
				check_rng("gate_match", c, 128);
			else
				check("gate_hold", c, 16'h0000);
			rd(OFS_GATE_CTRL, q);
			check("gate_value", {15'h0000, q[GC_VAL]}, {15'h0000, i[0] == i[1]});
		end
		run(8'h41, 8'h82, 128, c);
		check_rng("gate_reserved", c, 128);
		comp_run <= 1'b1;
		run(8'h41, 8'hC1, 128, c);
		check_rng("gate_companion", c, 8);
		comp_run <= 1'b0;
		$display("test gate done");
	endtask : test_gate
	task test_ext();
		logic [15:0] c;
		int hi_n;
		ext_run <= 1'b1;
		run(8'h81, 8'h00, 128, c);
		check_rng("ext_sync", c, 16);
		run(8'h85, 8'h00, 128, c);
		check_rng("ext_nosync", c, 16);
		ext_run <= 1'b0;
		xtal_run <= 1'b1;
		wr(OFS_TIMER_CTRL, 8'h08);
		sleep <= 1'b1;
		hi_n = 0;
		repeat (32)
		begin
			@(posedge mclk);
			hi_n += crystal_out;
		end
		sleep <= 1'b0;
		check_rng("crystal_sleep", hi_n[15:0], 16);
		run(8'h89, 8'h00, 128, c);
		check_rng("crystal", c, 16);
		xtal_run <= 1'b0;
		$display("test external done");
	endtask : test_ext
	task test_ovf();
		logic [7:0] q;
		int n;
		wr(OFS_TIMER_CTRL, 8'h00);
		wr(OFS_COUNT_LOW, 8'hFE);
		wr(OFS_COUNT_HIGH, 8'hFF);
		wr(OFS_TIMER_CTRL, 8'h41);
		repeat (8) @(posedge mclk);
		wr(OFS_TIMER_CTRL, 8'h00);
		rd(OFS_STATUS, q);
		check("ovf_status", {8'h00, q}, 16'h0001);
		check("ovf_flag", {15'h0000, ovf_flag}, 16'h0001);
		wr(OFS_STATUS, 8'h01);
		rd(OFS_STATUS, q);
		check("ovf_cleared", {8'h00, q}, 16'h0000);
		wr(OFS_COUNT_LOW, 8'hFF);
		wr(OFS_COUNT_HIGH, 8'hFF);
		sleep <= 1'b1;
		wr(OFS_TIMER_CTRL, 8'h85);
		ext_run <= 1'b1;
		n = 0;
		while (wake_pulse !== 1'b1 && n < 200)
		begin
			@(posedge mclk);
			n++;
		end
		check("wake", {15'h0000, wake_pulse}, 16'h0001);
		sleep <= 1'b0;
		ext_run <= 1'b0;
		wr(OFS_TIMER_CTRL, 8'h00);
		$display("test overflow done");
	endtask : test_ovf
	// ==========================================
	// Run control
	task final_report();
		$display("checks %0d miscompares %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : final_report
	initial
	begin
		#60000;
		miscompares++;
		final_report();
	end
	initial
	begin
		repeat (5) @(posedge mclk);
		rst_n <= 1'b1;
		repeat (3) @(posedge mclk);
		test_reset();
		test_bytes();
		test_clocks();
		test_gate();
		test_ext();
		test_ovf();
		final_report();
	end
endmodule : testbench
